// file: rtl/poc_pkg.sv
// Shared constants and types for the converter output control block.
// Assumes a single 40 MHz clock and an active-high asynchronous reset.
package poc_pkg;
  // ----------------------------------------------------------------
  // Widths and codes
  // ----------------------------------------------------------------
  localparam int SAMPLE_WIDTH = 14;
  localparam int PIPE_LATENCY = 7;
  localparam logic [13:0] MID_CODE = 14'h2000;
  localparam logic [13:0] ZERO_CODE = 14'h0000;
  localparam int MSB_POS = 13;

  // ----------------------------------------------------------------
  // Select pin levels (analog level already resolved to a code)
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEL_GROUND = 2'h0,
    SEL_MIDREF = 2'h1,
    SEL_SUPPLY = 2'h2,
    SEL_FLOAT = 2'h3
  } poc_sel_type;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 40;
  localparam int RECOVERY_TIME_US = 280;
  localparam int RECOVERY_CYCLES = RECOVERY_TIME_US * CLK_FREQ_MHZ;
  localparam int DUTY_MIN_PCT = 20;
  localparam int DUTY_MAX_PCT = 80;
  localparam int BUF_DEPTH = 2;
endpackage : poc_pkg

// file: rtl/poc_output_control.sv
// Output side of a 14-bit pipelined converter: format coding, latency, power-down.
// Assumes the sample quantiser and duty stabiliser analog live outside; inputs sync to clk.
`timescale 1ns/1ps
module poc_output_control
  import poc_pkg::*;
#(
  parameter int RECOVERY_COUNT = RECOVERY_CYCLES
) (
  input wire logic clk, // Converter clock
  input wire logic rst, // Async reset
  input wire logic [13:0] sampleCode, // Raw quantiser word, offset binary
  input wire logic singleEnded, // Input wired single-ended
  input wire logic [1:0] formatStabilizerSelect, // Resolved select pin level
  input wire logic powerDownPin, // High holds power-down
  input wire logic outReady, // Receiver can take a word
  output logic [13:0] dataOut, // Coded output word
  output logic outValid, // Word on dataOut is present
  output logic stabilizerOn, // Duty stabiliser enable
  output logic twosComplement, // Current output format
  output logic settled // Recovery and latency both elapsed
);
  typedef struct packed {
    logic [PIPE_LATENCY-1:0][13:0] pipe;
    logic [PIPE_LATENCY-1:0] pipeValid;
    logic [1:0][13:0] holdBuf;
    logic [1:0] bufValid;
    logic rdPtr;
    logic wrPtr;
    logic [31:0] recovCount;
    logic [3:0] latCount;
    logic stab;
    logic twos;
  } poc_state_type;

  poc_state_type state_reg, state_next;

  // ----------------------------------------------------------------
  // Select decoding
  // ----------------------------------------------------------------
  function automatic logic [1:0] decode_sel(input logic [1:0] sel);
    // Returns {stabiliser, twos}
    case (sel)
      SEL_SUPPLY: decode_sel = 2'h2;
      SEL_GROUND: decode_sel = 2'h3;
      SEL_MIDREF: decode_sel = 2'h1;
      default: decode_sel = 2'h0;
    endcase
  endfunction : decode_sel

  logic [1:0] selDec;
  logic pipeAdvance;
  logic bufFull;
  logic pushOk;
  logic popOk;
  logic [13:0] coded;

  always_comb begin
    selDec = decode_sel(formatStabilizerSelect);
    // Single-ended and differential share the code map; the span differs in analog only
    // Top bit flip gives twos complement, zero input lands at 0x0000
    coded = sampleCode ^ (state_reg.twos ? MID_CODE : ZERO_CODE);
    bufFull = &state_reg.bufValid;
    // Pipeline stalls rather than drops when the buffer is full
    pipeAdvance = !powerDownPin && !(bufFull && state_reg.pipeValid[PIPE_LATENCY-1]);
    pushOk = pipeAdvance && state_reg.pipeValid[PIPE_LATENCY-1];
    popOk = state_reg.bufValid[state_reg.rdPtr] && outReady;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    // Format change takes effect immediately; receiver discards a few words
    state_next.stab = selDec[1];
    state_next.twos = selDec[0];
    if (powerDownPin) begin
      // Pipeline and buffer contents are discarded
      state_next.pipeValid = '0;
      state_next.bufValid = '0;
      state_next.rdPtr = 1'b0;
      state_next.wrPtr = 1'b0;
      state_next.recovCount = 32'(RECOVERY_COUNT);
      state_next.latCount = 4'(PIPE_LATENCY);
    end else begin
      if (state_reg.recovCount != 32'h0) begin
        state_next.recovCount = state_reg.recovCount - 32'h1;
      end
      if (pipeAdvance && state_reg.recovCount == 32'h0 && state_reg.latCount != 4'h0) begin
        state_next.latCount = state_reg.latCount - 4'h1;
      end
      if (pipeAdvance) begin
        // One word per clock through seven stages
        state_next.pipe[0] = coded;
        state_next.pipeValid[0] = 1'b1;
        for (int i = 1; i < PIPE_LATENCY; i++) begin
          state_next.pipe[i] = state_reg.pipe[i-1];
          state_next.pipeValid[i] = state_reg.pipeValid[i-1];
        end
      end
      if (popOk) begin
        state_next.bufValid[state_reg.rdPtr] = 1'b0;
        state_next.rdPtr = ~state_reg.rdPtr;
      end
      if (pushOk) begin
        state_next.holdBuf[state_reg.wrPtr] = state_reg.pipe[PIPE_LATENCY-1];
        state_next.bufValid[state_reg.wrPtr] = 1'b1;
        state_next.wrPtr = ~state_reg.wrPtr;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign dataOut = state_reg.holdBuf[state_reg.rdPtr];
  assign outValid = state_reg.bufValid[state_reg.rdPtr] && !powerDownPin;
  assign stabilizerOn = state_reg.stab;
  assign twosComplement = state_reg.twos;
  assign settled = (state_reg.recovCount == 32'h0) && (state_reg.latCount == 4'h0);
endmodule : poc_output_control

// file: test/poc_output_control_asserts.sv
// Port checker for the converter output control block.
// Assumes one clock and a bind onto poc_output_control.
`timescale 1ns/1ps
module poc_checker #(parameter int RECOVERY_COUNT = 20) (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic [1:0] formatStabilizerSelect, // Select
  input wire logic powerDownPin, // Power-down
  input wire logic outReady, // Ready
  input wire logic [13:0] dataOut, // Word
  input wire logic outValid, // Valid
  input wire logic stabilizerOn, // Stabiliser
  input wire logic twosComplement, // Format
  input wire logic settled // Settled
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence stall_s;
    outValid && !outReady && !powerDownPin ##1 !powerDownPin;
  endsequence
  stab_decode_a: assert property (1'h1 |=>
    stabilizerOn == ($past(formatStabilizerSelect) inside {2'h0, 2'h2}))
    else $error("stabiliser decode");
  twos_decode_a: assert property (1'h1 |=>
    twosComplement == ($past(formatStabilizerSelect) inside {2'h0, 2'h1}))
    else $error("format decode");
  pd_novalid_a: assert property (powerDownPin |-> !outValid)
    else $error("valid in power-down");
  word_hold_a: assert property (stall_s |-> outValid && $stable(dataOut))
    else $error("word not held");
  settle_drop_a: assert property (powerDownPin |=> !settled)
    else $error("settled in power-down");
  settle_wait_a: assert property ($fell(powerDownPin) |-> !settled [*8])
    else $error("settled too soon");
  settle_bound_a: assert property ($fell(powerDownPin) |->
    ##[27:60] (settled || powerDownPin)) else $error("never settled");
  fresh_pipe_a: assert property ($fell(powerDownPin) |-> !outValid [*7])
    else $error("stale word");
endmodule : poc_checker
bind poc_output_control poc_checker #(.RECOVERY_COUNT(RECOVERY_COUNT)) u_poc_checker (
  .clk(clk), .rst(rst), .formatStabilizerSelect(formatStabilizerSelect),
  .powerDownPin(powerDownPin), .outReady(outReady), .dataOut(dataOut), .outValid(outValid),
  .stabilizerOn(stabilizerOn), .twosComplement(twosComplement), .settled(settled));

// file: test/poc_rx_model.sv
// Receiving capture logic model: drives ready only.
// Assumes the converter clock; ready moves on the falling edge.
`timescale 1ns/1ps
module poc_rx_model (
  input wire logic clk, // Converter clock
  output logic outReady // Ready toward block
);
  int seed = 95;
  initial outReady = 1'h0;
  // Random stalls force the buffer full and the pipeline to freeze
  always @(negedge clk) outReady <= ($random(seed) & 3) != 0;
endmodule : poc_rx_model

// file: test/testbench.sv
// Testbench: random and boundary samples in all four select modes.
// Assumes the receiver model for ready and a short recovery count.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'h0, rst = 1'h1, singleEnded = 1'h0, powerDownPin = 1'h1;
  logic [1:0] formatStabilizerSelect = 2'h0;
  logic [13:0] sampleCode = 14'h0000, dataOut;
  logic outReady, outValid, stabilizerOn, twosComplement, settled;
  logic [13:0] q[$];
  logic [13:0] edgeCodes[5] = '{14'h0000, 14'h1000, 14'h2000, 14'h3000, 14'h3FFF};
  int n_mismatch = 0, comparisons = 0, seed = 95;
  always #12.5 clk = ~clk;
  poc_output_control #(.RECOVERY_COUNT(20)) u_poc_output_control (.clk(clk), .rst(rst),
    .sampleCode(sampleCode), .singleEnded(singleEnded),
    .formatStabilizerSelect(formatStabilizerSelect), .powerDownPin(powerDownPin),
    .outReady(outReady), .dataOut(dataOut), .outValid(outValid),
    .stabilizerOn(stabilizerOn), .twosComplement(twosComplement), .settled(settled));
  poc_rx_model u_poc_rx_model (.clk(clk), .outReady(outReady));
  task automatic bad(input string msg);
    n_mismatch++;
    $display("BAD %0t %s", $time, msg);
  endtask : bad
  task automatic final_report;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  // Frozen pipeline drops samples, so unmatched older notes are skipped
  always @(posedge clk) if (outValid === 1'h1 && outReady === 1'h1 && settled === 1'h1) begin
    while (q.size() > 0 && q[0] !== dataOut) void'(q.pop_front());
    comparisons++;
    if (q.size() == 0) bad("unexpected word");
    else void'(q.pop_front());
  end
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk) rst = 1'h0;
    for (int m = 0; m < 4; m++) begin
      @(negedge clk) powerDownPin = 1'h1;
      formatStabilizerSelect = 2'(m);
      singleEnded = m[0];
      q.delete();
      repeat (3) @(negedge clk);
      comparisons++;
      if (stabilizerOn !== (m == 0 || m == 2) || twosComplement !== (m < 2)) bad("mode");
      powerDownPin = 1'h0;
      for (int i = 0; i < 90; i++) begin
        sampleCode = (i % 10 < 5) ? edgeCodes[i % 10] : 14'($random(seed));
        q.push_back((m < 2) ? sampleCode ^ 14'h2000 : sampleCode);
        @(negedge clk);
      end
      comparisons++;
      if (settled !== 1'h1) bad("not settled");
      $display("Mode %0d done", m);
    end
    final_report();
  end
endmodule : testbench
